/* scss_top.sv */
// register file and slot sequencer of the six-channel switch
`timescale 1ns/1ps
module scss_top #(
    parameter int SLOT_CYC0 = scss_pkg::SLOT_CYC0,
    parameter int SLOT_CYC1 = scss_pkg::SLOT_CYC1,
    parameter int SLOT_CYC2 = scss_pkg::SLOT_CYC2,
    parameter int SLOT_CYC3 = scss_pkg::SLOT_CYC3
) (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic ADDR_SEL_I,
    input wire logic WR_STB_I,
    input wire logic RD_STB_I,
    input wire logic [6:0] DEV_ADDR_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] WDATA_I,
    output logic ACK_O,
    output logic [7:0] RDATA_O,
    output logic [scss_pkg::NUM_CH-1:0] CH_ON_O,
    output logic [scss_pkg::NUM_CH-1:0] PROTECT_EN_O
);
    import scss_pkg::*;

    logic addr_sel;
    logic [NUM_CH-1:0] direct_on_q;
    logic [NUM_CH-1:0] protect_q;
    logic [NUM_CH*3-1:0] slot_sel_q;
    logic [1:0] period_sel_q;
    scss_state_t state_q;
    logic up_q;
    logic [2:0] cur_slot_q;
    logic [CNT_W-1:0] cnt_q;
    logic [NUM_CH-1:0] sequence_active_q;
    logic [NUM_CH-1:0] sequence_active_d;
    logic [NUM_CH-1:0] ch_on_d;

    scss_sync u_addr_sync (
        .clk_i(CLOCK_I),
        .rst_i(RST_I),
        .pin_i(ADDR_SEL_I),
        .level_o(addr_sel)
    );

    // bus address follows the filtered select pin
    wire [6:0] own_addr = addr_sel ? BUS_ADDR_HIGH : BUS_ADDR_LOW;
    wire hit = (DEV_ADDR_I == own_addr);
    wire wr = WR_STB_I && hit;
    wire rd = RD_STB_I && hit && !WR_STB_I;
    wire ack_d = wr || rd;

    // one offset decode serves both the write enables and the read mux
    wire at_direct = (REG_ADDR_I == ADDR_DIRECT_ON);
    wire at_slot12 = (REG_ADDR_I == ADDR_SLOT_CH12);
    wire at_slot34 = (REG_ADDR_I == ADDR_SLOT_CH34);
    wire at_slot56 = (REG_ADDR_I == ADDR_SLOT_CH56);
    wire at_ctrl = (REG_ADDR_I == ADDR_SEQUENCE_COMMAND);
    wire at_protect = (REG_ADDR_I == ADDR_PROTECT);
    wire at_state = (REG_ADDR_I == ADDR_CH_STATE);
    wire at_restore = (REG_ADDR_I == ADDR_RESTORE);
    wire wr_direct = wr && at_direct;
    wire wr_slot12 = wr && at_slot12;
    wire wr_slot34 = wr && at_slot34;
    wire wr_slot56 = wr && at_slot56;
    wire wr_ctrl = wr && at_ctrl;
    wire wr_protect = wr && at_protect;
    wire restore = wr && at_restore && (WDATA_I == RESTORE_KEY);

    // the command field is never stored, only decoded on the write
    wire [1:0] cmd = WDATA_I[CMD_LSB+1:CMD_LSB];
    wire start_up = wr_ctrl && (cmd == CMD_POWER_UP) && (state_q == SCSS_IDLE);
    wire start_dn = wr_ctrl && (cmd == CMD_SHUTDOWN) && (state_q == SCSS_IDLE);
    wire start = start_up || start_dn;
    wire [1:0] period_wr = WDATA_I[PERIOD_SEL_LSB+1:PERIOD_SEL_LSB];
    wire active = (state_q == SCSS_RUN);

    wire [CNT_W-1:0] period_cyc =
        (period_sel_q == 2'h0) ? CNT_W'(SLOT_CYC0) :
        (period_sel_q == 2'h1) ? CNT_W'(SLOT_CYC1) :
        (period_sel_q == 2'h2) ? CNT_W'(SLOT_CYC2) : CNT_W'(SLOT_CYC3);
    // a shorter period written mid-run must not wait for the counter to wrap
    wire slot_done = active && (cnt_q >= period_cyc - CNT_W'(1));
    wire last_slot = up_q ? (cur_slot_q == SLOT_LAST) : (cur_slot_q == SLOT_FIRST);
    wire advance = slot_done && !last_slot;
    wire finish = slot_done && last_slot;
    wire [2:0] next_slot = up_q ? cur_slot_q + 3'h1 : cur_slot_q - 3'h1;
    wire [2:0] apply_slot = start ? (start_up ? SLOT_FIRST : SLOT_LAST) : next_slot;
    wire apply_en = start || advance;
    wire apply_on = start ? start_up : up_q;

    // all channels sharing the entered slot switch on the same edge
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            wire [2:0] sel = slot_sel_q[g*3 +: 3];
            wire hit_slot = apply_en && (sel == apply_slot);
            assign sequence_active_d[g] = hit_slot ? apply_on : sequence_active_q[g];
            // slot 000 hands the channel to its direct enable bit
            assign ch_on_d[g] = (sel == SLOT_NONE) ? direct_on_q[g] : sequence_active_q[g];
        end
    endgenerate

    // one process owns the whole run-driven vector
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            sequence_active_q <= '0;
        end else if (restore) begin
            sequence_active_q <= '0;
        end else begin
            sequence_active_q <= sequence_active_d;
        end
    end

    wire [7:0] ctrl_rd = {period_sel_q, 2'b00, active, cur_slot_q};
    wire [7:0] rd_mux =
        at_direct ? {2'b00, direct_on_q} :
        at_slot12 ? {2'b00, slot_sel_q[5:0]} :
        at_slot34 ? {2'b00, slot_sel_q[11:6]} :
        at_slot56 ? {2'b00, slot_sel_q[17:12]} :
        at_ctrl ? ctrl_rd :
        at_protect ? {2'b00, protect_q} :
        at_state ? {2'b00, CH_ON_O} :
        RESET_BYTE; // restore register and unmapped addresses read 00

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            direct_on_q <= '0;
        end else if (restore) begin
            direct_on_q <= '0;
        end else if (wr_direct) begin
            direct_on_q <= WDATA_I[NUM_CH-1:0];
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            protect_q <= '0;
        end else if (restore) begin
            protect_q <= '0;
        end else if (wr_protect) begin
            protect_q <= WDATA_I[NUM_CH-1:0];
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            period_sel_q <= 2'h0;
        end else if (restore) begin
            period_sel_q <= 2'h0;
        end else if (wr_ctrl) begin
            period_sel_q <= period_wr;
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            slot_sel_q <= '0;
        end else if (restore) begin
            slot_sel_q <= '0;
        end else begin
            if (wr_slot12) begin
                slot_sel_q[5:0] <= WDATA_I[5:0];
            end
            if (wr_slot34) begin
                slot_sel_q[11:6] <= WDATA_I[5:0];
            end
            if (wr_slot56) begin
                slot_sel_q[17:12] <= WDATA_I[5:0];
            end
        end
    end

    // a command written while a run is going is dropped, not queued
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            state_q <= SCSS_IDLE;
            up_q <= 1'b0;
            cur_slot_q <= SLOT_NONE;
            cnt_q <= '0;
        end else if (restore) begin
            state_q <= SCSS_IDLE;
            up_q <= 1'b0;
            cur_slot_q <= SLOT_NONE;
            cnt_q <= '0;
        end else begin
            case (state_q)
                SCSS_IDLE: begin
                    if (start) begin
                        state_q <= SCSS_RUN;
                        up_q <= start_up;
                        cur_slot_q <= apply_slot;
                        cnt_q <= '0;
                    end
                end
                SCSS_RUN: begin
                    if (finish) begin
                        state_q <= SCSS_IDLE;
                        cur_slot_q <= SLOT_NONE;
                        cnt_q <= '0;
                    end else if (advance) begin
                        cur_slot_q <= next_slot;
                        cnt_q <= '0;
                    end else begin
                        cnt_q <= cnt_q + CNT_W'(1);
                    end
                end
                default: begin
                    state_q <= SCSS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            ACK_O <= 1'b0;
            RDATA_O <= RESET_BYTE;
            CH_ON_O <= '0;
            PROTECT_EN_O <= '0;
        end else begin
            ACK_O <= ack_d;
            if (rd) begin
                RDATA_O <= rd_mux;
            end
            CH_ON_O <= ch_on_d;
            PROTECT_EN_O <= protect_q;
        end
    end
endmodule

/* scss_pkg.sv */
// constants and types of the six-channel switch sequencer
// Contract
// - slot field 000 means direct enable; 001..111 select slots 1..7
// - 0x06 holds ch4 bits 5:3, ch3 bits 2:0; 0x07 ch6/ch5; reset 000
// - command 01 starts power-up, slots 1 up to 7
// - command 10 starts shutdown, slots 7 down to 1
// - command 11 and 00 start nothing
// - command field clears at once and reads 00
// - bit 3 reads 1 while a run is in progress, else 0
// - bits 2:0 show the slot now running, 000 when idle
// - 0x0A bits 5:0 are read/write protection enables; bits 7:6 read 0
// - 0x0B bits 5:0 show each channel on or off; bits 7:6 read 0
// - writing B0 to 0x69 returns every register to its default
// - restore register always reads 00
// - 0x02 bits 5:0 directly switch channels whose slot field is 000
// - bus address 0011000 with select pin low, 0011001 with it high
package scss_pkg;
    localparam int NUM_CH = 6;
    localparam logic [7:0] ADDR_DIRECT_ON = 8'h02;
    localparam logic [7:0] ADDR_SLOT_CH12 = 8'h05;
    localparam logic [7:0] ADDR_SLOT_CH34 = 8'h06;
    localparam logic [7:0] ADDR_SLOT_CH56 = 8'h07;
    localparam logic [7:0] ADDR_SEQUENCE_COMMAND = 8'h08;
    localparam logic [7:0] ADDR_PROTECT = 8'h0A;
    localparam logic [7:0] ADDR_CH_STATE = 8'h0B;
    localparam logic [7:0] ADDR_RESTORE = 8'h69;
    localparam logic [7:0] RESTORE_KEY = 8'hB0;
    localparam logic [6:0] BUS_ADDR_LOW = 7'h18;
    localparam logic [6:0] BUS_ADDR_HIGH = 7'h19;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [2:0] SLOT_NONE = 3'h0;
    localparam logic [2:0] SLOT_FIRST = 3'h1;
    localparam logic [2:0] SLOT_LAST = 3'h7;
    localparam logic [1:0] CMD_POWER_UP = 2'h1;
    localparam logic [1:0] CMD_SHUTDOWN = 2'h2;
    localparam int PERIOD_SEL_LSB = 6;
    localparam int CMD_LSB = 4;
    localparam int ACTIVE_BIT = 3;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int SLOT_TIME0_US = 700;
    localparam int SLOT_TIME1_US = 1300;
    localparam int SLOT_TIME2_US = 1900;
    localparam int SLOT_TIME3_US = 2500;
    // scaled in nanoseconds so the longest slot stays inside a 32-bit int
    localparam int SLOT_CYC0 = SLOT_TIME0_US * 1000 / (CLK_PERIOD_PS / 1000);
    localparam int SLOT_CYC1 = SLOT_TIME1_US * 1000 / (CLK_PERIOD_PS / 1000);
    localparam int SLOT_CYC2 = SLOT_TIME2_US * 1000 / (CLK_PERIOD_PS / 1000);
    localparam int SLOT_CYC3 = SLOT_TIME3_US * 1000 / (CLK_PERIOD_PS / 1000);
    localparam int CNT_W = 20;
    typedef enum logic {
        SCSS_IDLE,
        SCSS_RUN
    } scss_state_t;
endpackage

/* scss_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module scss_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic level_o
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_o <= 1'b0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_o <= s3_q;
            end
        end
    end
endmodule

/* scss_asserts.sv */
// port assertions for the switch sequencer
`timescale 1ns/1ps
module scss_asserts (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic ADDR_SEL_I,
    input wire logic WR_STB_I,
    input wire logic RD_STB_I,
    input wire logic [6:0] DEV_ADDR_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic ACK_O,
    input wire logic [7:0] RDATA_O,
    input wire logic [5:0] CH_ON_O,
    input wire logic [5:0] PROTECT_EN_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    // both legal bus addresses differ only in bit 0
    wire logic hit = DEV_ADDR_I[6:1] == 6'h0C;
    wire logic rd_only = RD_STB_I && !WR_STB_I;
    ack_needs_hit_a: assert property (ACK_O |-> $past(WR_STB_I | RD_STB_I) && $past(hit))
        else $error("ack without an addressed access");
    foreign_no_ack_a: assert property ((WR_STB_I | RD_STB_I) && !hit |=> !ACK_O)
        else $error("ack for a foreign bus address");
    protect_by_write_a: assert property ($changed(PROTECT_EN_O) |-> $past(WR_STB_I) || $past(WR_STB_I, 2))
        else $error("protect enables moved without a write");
    protect_read_a: assert property (rd_only && REG_ADDR_I == 8'h0A ##1 ACK_O |-> RDATA_O == {2'b00, PROTECT_EN_O})
        else $error("protect register read wrong");
    restore_reads_zero_a: assert property (rd_only && REG_ADDR_I == 8'h69 ##1 ACK_O |-> RDATA_O == 8'h00)
        else $error("restore register read nonzero");
    state_read_a: assert property (rd_only && REG_ADDR_I == 8'h0B ##1 ACK_O |-> RDATA_O == {2'b00, $past(CH_ON_O)})
        else $error("channel state read differs from outputs");
    cmd_reads_zero_a: assert property (rd_only && REG_ADDR_I == 8'h08 ##1 ACK_O |-> RDATA_O[5:4] == 2'b00)
        else $error("command field read nonzero");
    active_slot_a: assert property (rd_only && REG_ADDR_I == 8'h08 ##1 ACK_O |-> RDATA_O[3] == (RDATA_O[2:0] != 3'h0))
        else $error("active flag and slot disagree");
    cover property (rd_only && REG_ADDR_I == 8'h08 ##1 ACK_O && RDATA_O[3]);
    cover property (WR_STB_I && REG_ADDR_I == 8'h69 && WDATA_I == 8'hB0 ##1 ACK_O);
    cover property (CH_ON_O == 6'h3F);
endmodule
bind scss_top scss_asserts i_scss_asserts (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .ADDR_SEL_I(ADDR_SEL_I),
    .WR_STB_I(WR_STB_I), .RD_STB_I(RD_STB_I), .DEV_ADDR_I(DEV_ADDR_I), .REG_ADDR_I(REG_ADDR_I),
    .WDATA_I(WDATA_I), .ACK_O(ACK_O), .RDATA_O(RDATA_O), .CH_ON_O(CH_ON_O),
    .PROTECT_EN_O(PROTECT_EN_O));

/* scss_host.sv */
// bus-master model issuing framed single-byte register accesses
`timescale 1ns/1ps
module scss_host (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [7:0] rdata_i,
    output logic wr_stb_o = 1'b0,
    output logic rd_stb_o = 1'b0,
    output logic [6:0] dev_addr_o = 7'h00,
    output logic [7:0] reg_addr_o = 8'h00,
    output logic [7:0] wdata_o = 8'h00
);
    task automatic xfer(input logic w, input logic [6:0] dev, input logic [7:0] ra, wd,
        output logic k, output logic [7:0] r);
        @(posedge clk_i);
        wr_stb_o <= w;
        rd_stb_o <= !w;
        dev_addr_o <= dev;
        reg_addr_o <= ra;
        wdata_o <= wd;
        @(posedge clk_i);
        wr_stb_o <= 1'b0;
        rd_stb_o <= 1'b0;
        // released lines show no stale value
        dev_addr_o <= ~dev;
        reg_addr_o <= ~ra;
        wdata_o <= ~wd;
        #1;
        k = ack_i;
        r = rdata_i;
    endtask
endmodule

/* scss_top_tb.sv */
// self-checking testbench of the switch sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module scss_top_tb;
    import scss_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sel = 1'b0;
    logic wr_stb, rd_stb, ack, k;
    logic [6:0] dev;
    logic [7:0] ra, wd, rdata, r;
    logic [5:0] ch_on, prot;
    int n_errors = 0;
    int checked = 0;
    logic [2:0] slot_of [6] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h2, 3'h7};
    logic [7:0] regs [8] = '{ADDR_DIRECT_ON, ADDR_SLOT_CH12, ADDR_SLOT_CH34, ADDR_SLOT_CH56, ADDR_SEQUENCE_COMMAND,
        ADDR_PROTECT, ADDR_CH_STATE, ADDR_RESTORE};
    always #4 clk = ~clk;
    // short slot periods keep the four runs brief
    scss_top #(.SLOT_CYC0(40), .SLOT_CYC1(50), .SLOT_CYC2(60), .SLOT_CYC3(70)) i_scss_top (
        .CLOCK_I(clk), .RST_I(rst), .ADDR_SEL_I(sel), .WR_STB_I(wr_stb), .RD_STB_I(rd_stb),
        .DEV_ADDR_I(dev), .REG_ADDR_I(ra), .WDATA_I(wd), .ACK_O(ack), .RDATA_O(rdata),
        .CH_ON_O(ch_on), .PROTECT_EN_O(prot));
    scss_host i_scss_host (.clk_i(clk), .ack_i(ack), .rdata_i(rdata), .wr_stb_o(wr_stb),
        .rd_stb_o(rd_stb), .dev_addr_o(dev), .reg_addr_o(ra), .wdata_o(wd));
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, v);
        logic kk;
        logic [7:0] rr;
        i_scss_host.xfer(1'b1, BUS_ADDR_LOW, a, v, kk, rr);
        `CHK(kk, 1'b1)
    endtask
    task automatic rchk(input logic [7:0] a, e);
        logic kk;
        logic [7:0] rr;
        i_scss_host.xfer(1'b0, BUS_ADDR_LOW, a, 8'h00, kk, rr);
        `CHK(kk, 1'b1)
        `CHK(rr, e)
    endtask
    function automatic logic [5:0] exp_on(input logic up, input int n);
        exp_on = 6'h03;
        for (int c = 2; c < 6; c++) begin
            if (up ? (slot_of[c] <= n) : (slot_of[c] < n)) begin
                exp_on[c] = 1'b1;
            end
        end
    endfunction
    // reads land mid-slot; a start command during the run must be dropped
    task automatic run(input logic up, input logic [1:0] ps, input int p);
        int n;
        wreg(ADDR_SEQUENCE_COMMAND, {ps, up ? CMD_POWER_UP : CMD_SHUTDOWN, 4'h0});
        repeat (p / 2) @(posedge clk);
        for (int i = 1; i <= 7; i++) begin
            n = up ? i : 8 - i;
            wreg(ADDR_SEQUENCE_COMMAND, {ps, up ? CMD_SHUTDOWN : CMD_POWER_UP, 4'h0});
            rchk(ADDR_SEQUENCE_COMMAND, {ps, 3'h1, 3'(n)});
            `CHK(ch_on, exp_on(up, n))
            repeat (p - 4) @(posedge clk);
        end
        rchk(ADDR_SEQUENCE_COMMAND, {ps, 6'h00});
        `CHK(ch_on, exp_on(up, up ? 8 : 0))
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        stop_test();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        foreach (regs[i]) rchk(regs[i], 8'h00);
        wreg(ADDR_PROTECT, 8'hFF);
        rchk(ADDR_PROTECT, 8'h3F);
        `CHK(prot, 6'h3F)
        wreg(ADDR_SLOT_CH34, 8'hD1);
        wreg(ADDR_SLOT_CH56, 8'hFA);
        rchk(ADDR_SLOT_CH34, 8'h11);
        rchk(ADDR_SLOT_CH56, 8'h3A);
        wreg(ADDR_DIRECT_ON, 8'h3F);
        rchk(ADDR_CH_STATE, 8'h03);
        wreg(ADDR_SEQUENCE_COMMAND, 8'h30);
        rchk(ADDR_SEQUENCE_COMMAND, 8'h00);
        wreg(ADDR_SEQUENCE_COMMAND, 8'hC0);
        rchk(ADDR_SEQUENCE_COMMAND, 8'hC0);
        for (int j = 0; j < 4; j++) run(j[0] == 1'b0, 2'(j), 40 + 10 * j);
        wreg(ADDR_DIRECT_ON, 8'h3E);
        rchk(ADDR_CH_STATE, 8'h02);
        i_scss_host.xfer(1'b1, BUS_ADDR_HIGH, ADDR_DIRECT_ON, 8'h00, k, r);
        `CHK(k, 1'b0)
        i_scss_host.xfer(1'b1, 7'h2A, ADDR_DIRECT_ON, 8'h00, k, r);
        `CHK(k, 1'b0)
        rchk(ADDR_CH_STATE, 8'h02);
        wreg(ADDR_RESTORE, 8'h12);
        rchk(ADDR_PROTECT, 8'h3F);
        rchk(ADDR_RESTORE, 8'h00);
        wreg(ADDR_RESTORE, RESTORE_KEY);
        foreach (regs[i]) rchk(regs[i], 8'h00);
        @(posedge clk);
        sel <= 1'b1;
        repeat (6) @(posedge clk);
        i_scss_host.xfer(1'b0, BUS_ADDR_HIGH, ADDR_CH_STATE, 8'h00, k, r);
        `CHK(k, 1'b1)
        i_scss_host.xfer(1'b0, BUS_ADDR_LOW, ADDR_CH_STATE, 8'h00, k, r);
        `CHK(k, 1'b0)
        stop_test();
    end
endmodule
